// ---- core/bpl_consts.svh ----
`ifndef BPL_CONSTS_SVH
`define BPL_CONSTS_SVH

// Clocking
`define CLOCK_PERIOD_NS      100
`define LINK_PERIOD_NS       800
`define LINK_DIV_CYCLES      ((`LINK_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define LINK_DIV_W           3
`define LINK_SAMPLE_PHASE    3'h1
`define LINK_UPDATE_PHASE    3'h7
`define DS_BIT_CYCLES        (`LINK_DIV_CYCLES / 2)

// Bus reset duration
`define BUS_RESET_NS         8000
`define BUS_RESET_CYCLES     ((`BUS_RESET_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define RESET_CNT_W          8

// Register map
`define REG_ADDR_W           4
`define REG_DATA_W           8
`define REG_NODE_ADDR        4'h0
`define REG_DRV_RST          4'h1
`define REG_RESERVED         4'h3
`define REG_PRIORITY         4'h4
`define NODE_ADDR_W          6
`define PRIORITY_W           4
`define INHIBIT_BIT          0
`define BUS_RESET_BIT        1
`define NODE_ADDR_RESET      6'h00
`define PRIORITY_RESET       4'h0
`define INHIBIT_RESET        1'h0

// Serial request stream
`define REQ_CNT_W            5
`define REQ_SHIFT_W          16
`define REQ_TYPE_POS         5'h4
`define REQ_LEN_BUS          5'd11
`define REQ_LEN_READ         5'd9
`define REQ_LEN_WRITE        5'd17
`define REQ_LEN_UNKNOWN      5'h1f
`define REQ_TYPE_READ        3'h4
`define REQ_TYPE_WRITE       3'h5

// Control codes
`define PHY_CTL_IDLE         2'h0
`define PHY_CTL_STATUS       2'h1
`define PHY_CTL_RECEIVE      2'h2
`define PHY_CTL_GRANT        2'h3
`define LINK_CTL_RELEASE     2'h0
`define LINK_CTL_HOLD        2'h1
`define LINK_CTL_TRANSMIT    2'h2

// Arbitration and status
`define ARB_BITS             10
`define ARB_CNT_W            4
`define STATUS_READ_PERIODS  4
`define STATUS_RESET_WORD    8'h40

// Receive buffer
`define RX_FIFO_DEPTH        8

`endif

// ---- core/bpl_pkg.sv ----
package bpl_pkg;
  `include "bpl_consts.svh"

  typedef enum logic [2:0] {
    ST_IDLE, ST_BUS_RESET, ST_STATUS, ST_RECEIVE, ST_ARBITRATE, ST_GRANT, ST_LINK_OWNS
  } phy_state_t;

  // Bit 1 of each field is line 0, so a code reads as line 0 then line 1
  typedef struct packed {
    logic [1:0] ctl;
    logic [1:0] data;
  } link_bus_t;

  typedef struct packed {
    logic       last;
    logic [1:0] data;
  } rx_word_t;

  typedef struct packed {
    phy_state_t                state;
    logic [`LINK_DIV_W-1:0]    div;
    logic                      clk_out;
    logic [5:0]                sync1;
    logic [5:0]                sync2;
    logic [`NODE_ADDR_W-1:0]   node_address;
    logic                      inhibit;
    logic                      reset_req;
    logic [`PRIORITY_W-1:0]    priority_level;
    logic                      req_active;
    logic [`REQ_CNT_W-1:0]     req_count;
    logic [`REQ_CNT_W-1:0]     req_len;
    logic [`REQ_SHIFT_W-1:0]   req_shift;
    logic                      arb_pending;
    logic                      read_pending;
    logic                      status_pending;
    logic [`REG_DATA_W-1:0]    read_data;
    logic [`ARB_BITS-1:0]      arb_shift;
    logic [`ARB_CNT_W-1:0]     arb_cnt;
    logic                      arb_out;
    logic [`REG_DATA_W-1:0]    status_shift;
    logic [2:0]                status_left;
    logic [`RESET_CNT_W-1:0]   reset_cnt;
    logic                      rx_final;
    logic                      link_settle;
    link_bus_t                 bus_out;
    link_bus_t                 bus_oe;
    logic [1:0]                enc_pair;
    logic [`LINK_DIV_W-1:0]    enc_phase;
    logic                      enc_busy;
    logic                      enc_data;
    logic                      enc_strobe;
    logic                      tx_en;
    logic                      tx_data;
    logic                      tx_strobe;
  } phy_core_t;
endpackage : bpl_pkg

// ---- core/backplane_phy_link_interface.sv ----
`timescale 1ns/1ps

module rx_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            count;
    logic                        not_full;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;

  assign in_ready  = st_reg.not_full;
  assign out_valid = st_reg.count != '0;
  assign out_data  = st_reg.mem[st_reg.rd];

  always_comb begin
    st_next = st_reg;
    push    = in_valid & st_reg.not_full;
    pop     = out_ready & (st_reg.count != '0);
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == PTR_W'(DEPTH - 1)) ? '0 : st_reg.wr + PTR_W'(1);
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == PTR_W'(DEPTH - 1)) ? '0 : st_reg.rd + PTR_W'(1);
    end
    st_next.count    = st_reg.count + CNT_W'(push) - CNT_W'(pop);
    st_next.not_full = st_next.count != CNT_W'(DEPTH);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.not_full <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rx_fifo

module backplane_phy_link_interface
  import bpl_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  output logic           link_clock_out,
  input  wire link_bus_t link_bus_in,
  output link_bus_t      link_bus_out,
  output link_bus_t      link_bus_oe,
  input  wire logic      link_request_line,
  output logic           arb_drive_out,
  input  wire logic      backplane_readback,
  output logic           tx_encoded_data,
  output logic           tx_encoded_strobe,
  output logic           tx_drive_enable,
  input  wire rx_word_t  rx_word,
  input  wire logic      rx_valid,
  output logic           rx_ready
);
  phy_core_t              st_reg;
  phy_core_t              st_next;
  link_bus_t              sync_bus;
  logic                   sync_req;
  logic                   sync_rb;
  logic                   tick_sample;
  logic                   tick_update;
  logic [`REQ_SHIFT_W-1:0] nshift;
  logic [`REQ_CNT_W-1:0]  ncount;
  logic [`REG_DATA_W-1:0] status_src;
  logic                   enc_bit;
  logic                   pop;
  logic [2:0]             fifo_word_raw;
  rx_word_t               fifo_word;
  logic                   fifo_valid;

  function automatic logic [`REQ_CNT_W-1:0] req_length(input logic [2:0] req_type);
    if (req_type == `REQ_TYPE_READ) return `REQ_LEN_READ;
    if (req_type == `REQ_TYPE_WRITE) return `REQ_LEN_WRITE;
    return `REQ_LEN_BUS;
  endfunction : req_length

  function automatic logic [`REG_DATA_W-1:0] reg_read(input logic [`REG_ADDR_W-1:0] a, input phy_core_t s);
    logic [`REG_DATA_W-1:0] r;
    r = '0;
    case (a)
      `REG_NODE_ADDR: r[`NODE_ADDR_W-1:0] = s.node_address;
      `REG_DRV_RST: begin
        r[`INHIBIT_BIT]   = s.inhibit;
        r[`BUS_RESET_BIT] = s.reset_req;
      end
      `REG_PRIORITY: r[`PRIORITY_W-1:0] = s.priority_level;
      `REG_RESERVED: r = '0;
      default: r = '0;
    endcase
    return r;
  endfunction : reg_read

  rx_fifo #(
    .WIDTH ($bits(rx_word_t)),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (rx_word),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fifo_word_raw),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  assign fifo_word   = rx_word_t'(fifo_word_raw);
  // Only the second synchroniser stage is read
  assign sync_bus    = link_bus_t'(st_reg.sync2[5:2]);
  assign sync_req    = st_reg.sync2[1];
  assign sync_rb     = st_reg.sync2[0];
  // Sampling one cycle after the link edge sees the value present just before it
  assign tick_sample = st_reg.div == `LINK_SAMPLE_PHASE;
  // Registered here, so new values appear together with the rising link clock
  assign tick_update = st_reg.div == `LINK_UPDATE_PHASE;
  assign nshift      = {st_reg.req_shift[`REQ_SHIFT_W-2:0], sync_req};
  assign ncount      = st_reg.req_count + `REQ_CNT_W'(1);
  assign status_src  = st_reg.read_pending ? st_reg.read_data : `STATUS_RESET_WORD;
  assign enc_bit     = (st_reg.enc_phase < `LINK_DIV_W'(`DS_BIT_CYCLES)) ? st_reg.enc_pair[1] : st_reg.enc_pair[0];

  assign link_clock_out    = st_reg.clk_out;
  assign link_bus_out      = st_reg.bus_out;
  assign link_bus_oe       = st_reg.bus_oe;
  assign arb_drive_out     = st_reg.arb_out;
  assign tx_encoded_data   = st_reg.tx_data;
  assign tx_encoded_strobe = st_reg.tx_strobe;
  assign tx_drive_enable   = st_reg.tx_en;

  always_comb begin
    st_next       = st_reg;
    pop           = 1'b0;
    st_next.sync1 = {link_bus_in, link_request_line, backplane_readback};
    st_next.sync2 = st_reg.sync1;
    st_next.div   = (st_reg.div == `LINK_DIV_W'(`LINK_DIV_CYCLES - 1)) ? '0 : st_reg.div + `LINK_DIV_W'(1);
    st_next.clk_out = st_next.div < `LINK_DIV_W'(`LINK_DIV_CYCLES / 2);

    // Data-strobe encoder: strobe flips when data repeats
    if (st_reg.enc_busy) begin
      if (st_reg.enc_phase == '0 || st_reg.enc_phase == `LINK_DIV_W'(`DS_BIT_CYCLES)) begin
        st_next.enc_data = enc_bit;
        if (enc_bit == st_reg.enc_data) begin
          st_next.enc_strobe = ~st_reg.enc_strobe;
        end
      end
      st_next.enc_phase = st_reg.enc_phase + `LINK_DIV_W'(1);
      if (st_reg.enc_phase == `LINK_DIV_W'(`LINK_DIV_CYCLES - 1)) begin
        st_next.enc_busy = 1'b0;
      end
    end

    unique case (st_reg.state)
      ST_IDLE: begin
        if (tick_update) begin
          st_next.bus_oe  = '1;
          st_next.bus_out = '{ctl: `PHY_CTL_IDLE, data: 2'h0};
          if (st_reg.reset_req) begin
            st_next.state     = ST_BUS_RESET;
            st_next.reset_cnt = '0;
            st_next.arb_out   = 1'b1;
          end else if (fifo_valid) begin
            st_next.state       = ST_RECEIVE;
            st_next.rx_final    = 1'b0;
            st_next.bus_out.ctl = `PHY_CTL_RECEIVE;
          end else if (st_reg.read_pending || st_reg.status_pending) begin
            st_next.state        = ST_STATUS;
            st_next.bus_out      = '{ctl: `PHY_CTL_STATUS, data: status_src[7:6]};
            st_next.status_shift = {status_src[5:0], 2'h0};
            st_next.status_left  = st_reg.read_pending ? 3'(`STATUS_READ_PERIODS - 1) : 3'h0;
            if (st_reg.read_pending) begin
              st_next.read_pending = 1'b0;
            end else begin
              st_next.status_pending = 1'b0;
            end
          end else if (st_reg.arb_pending) begin
            st_next.state       = ST_ARBITRATE;
            st_next.arb_pending = 1'b0;
            st_next.arb_shift   = {st_reg.priority_level, st_reg.node_address};
            st_next.arb_cnt     = '0;
            st_next.arb_out     = st_reg.priority_level[`PRIORITY_W-1];
          end
        end
      end
      ST_BUS_RESET: begin
        if (st_reg.reset_cnt == `RESET_CNT_W'(`BUS_RESET_CYCLES - 1)) begin
          st_next.state          = ST_IDLE;
          st_next.reset_req      = 1'b0;
          st_next.status_pending = 1'b1;
          st_next.arb_out        = 1'b0;
        end else begin
          st_next.reset_cnt = st_reg.reset_cnt + `RESET_CNT_W'(1);
        end
      end
      ST_STATUS: begin
        if (tick_update) begin
          if (st_reg.status_left == '0) begin
            st_next.state   = ST_IDLE;
            st_next.bus_out = '{ctl: `PHY_CTL_IDLE, data: 2'h0};
          end else begin
            st_next.bus_out      = '{ctl: `PHY_CTL_STATUS, data: st_reg.status_shift[7:6]};
            st_next.status_shift = {st_reg.status_shift[5:0], 2'h0};
            st_next.status_left  = st_reg.status_left - 3'h1;
          end
        end
      end
      ST_RECEIVE: begin
        if (tick_update) begin
          if (st_reg.rx_final) begin
            st_next.state   = ST_IDLE;
            st_next.bus_out = '{ctl: `PHY_CTL_IDLE, data: 2'h0};
          end else begin
            // An underrun mid-packet shows as receive code with zero data
            st_next.bus_out = '{ctl: `PHY_CTL_RECEIVE, data: 2'h0};
            if (fifo_valid) begin
              pop                  = 1'b1;
              st_next.bus_out.data = fifo_word.data;
              st_next.rx_final     = fifo_word.last;
            end
          end
        end
      end
      ST_ARBITRATE: begin
        // Readback has settled for six cycles when the bit period ends
        if (tick_update) begin
          if (sync_rb != st_reg.arb_out) begin
            st_next.state   = ST_IDLE;
            st_next.arb_out = 1'b0;
          end else if (st_reg.arb_cnt == `ARB_CNT_W'(`ARB_BITS - 1)) begin
            st_next.state   = ST_GRANT;
            st_next.arb_out = 1'b0;
            st_next.bus_out = '{ctl: `PHY_CTL_GRANT, data: 2'h0};
          end else begin
            st_next.arb_shift = {st_reg.arb_shift[`ARB_BITS-2:0], 1'b0};
            st_next.arb_out   = st_reg.arb_shift[`ARB_BITS-2];
            st_next.arb_cnt   = st_reg.arb_cnt + `ARB_CNT_W'(1);
          end
        end
      end
      ST_GRANT: begin
        if (tick_update) begin
          st_next.state       = ST_LINK_OWNS;
          st_next.bus_oe      = '0;
          st_next.bus_out     = '0;
          st_next.link_settle = 1'b1;
        end
      end
      ST_LINK_OWNS: begin
        // The first sample after release still sees the grant code the device drove before release
        if (tick_sample) begin
          if (st_reg.link_settle) begin
            st_next.link_settle = 1'b0;
          end else if (sync_bus.ctl == `LINK_CTL_RELEASE) begin
            st_next.state = ST_IDLE;
          end else if (sync_bus.ctl == `LINK_CTL_TRANSMIT) begin
            st_next.enc_pair  = sync_bus.data;
            st_next.enc_phase = '0;
            st_next.enc_busy  = 1'b1;
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // Request receiver runs after the state machine so new requests are not lost
    if (tick_sample) begin
      if (!st_reg.req_active) begin
        if (sync_req) begin
          st_next.req_active = 1'b1;
          st_next.req_count  = `REQ_CNT_W'(1);
          st_next.req_shift  = '0;
          st_next.req_len    = `REQ_LEN_UNKNOWN;
        end
      end else begin
        st_next.req_shift = nshift;
        st_next.req_count = ncount;
        if (ncount == `REQ_TYPE_POS) begin
          st_next.req_len = req_length(nshift[2:0]);
        end else if (ncount == st_reg.req_len) begin
          st_next.req_active = 1'b0;
          if (st_reg.req_len == `REQ_LEN_READ) begin
            st_next.read_data    = reg_read(nshift[4:1], st_reg);
            st_next.read_pending = 1'b1;
          end else if (st_reg.req_len == `REQ_LEN_WRITE) begin
            case (nshift[12:9])
              `REG_NODE_ADDR: st_next.node_address = nshift[`NODE_ADDR_W:1];
              `REG_DRV_RST: begin
                st_next.inhibit = nshift[`INHIBIT_BIT+1];
                if (nshift[`BUS_RESET_BIT+1]) begin
                  st_next.reset_req = 1'b1;
                end
              end
              `REG_PRIORITY: st_next.priority_level = nshift[`PRIORITY_W:1];
              default: ;
            endcase
          end else begin
            st_next.arb_pending = 1'b1;
          end
        end
      end
    end

    st_next.tx_en     = st_next.enc_busy & ~st_next.inhibit;
    st_next.tx_data   = st_next.enc_data & st_next.tx_en;
    st_next.tx_strobe = st_next.enc_strobe & st_next.tx_en;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                <= '0;
      st_reg.state          <= ST_IDLE;
      st_reg.node_address   <= `NODE_ADDR_RESET;
      st_reg.priority_level <= `PRIORITY_RESET;
      st_reg.inhibit        <= `INHIBIT_RESET;
      st_reg.bus_oe         <= '1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : backplane_phy_link_interface

// ---- testbench/phy_link_checker.sv ----
`timescale 1ns/1ps
module phy_link_checker
  import bpl_pkg::*;
(
  input wire logic      clock,
  input wire logic      rst_n,
  input wire logic      link_clock_out,
  input wire link_bus_t link_bus_out,
  input wire link_bus_t link_bus_oe,
  input wire logic      arb_drive_out,
  input wire logic      tx_encoded_data,
  input wire logic      tx_encoded_strobe,
  input wire logic      tx_drive_enable,
  input wire logic      rx_valid,
  input wire logic      rx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Anchored on the fall: the first high phase after reset is one cycle short by design
  chk_link_clock: assert property ($fell(link_clock_out) |-> !link_clock_out[*4] ##1 link_clock_out[*4])
    else $error("link clock duty wrong");
  chk_bus_edge: assert property ($changed(link_bus_out) |-> $rose(link_clock_out))
    else $error("bus output changed off link edge");
  chk_oe_edge: assert property ($changed(link_bus_oe) |-> $rose(link_clock_out))
    else $error("bus enable changed off link edge");
  chk_arb_edge: assert property ($changed(arb_drive_out) |-> $rose(link_clock_out))
    else $error("arbitration bit changed off link edge");
  chk_grant_hold: assert property ($rose(link_bus_out.ctl == 2'h3) |->
    (link_bus_out.ctl == 2'h3)[*8] ##1 link_bus_oe == 4'h0)
    else $error("grant not one period then release");
  chk_tx_quiet: assert property (!tx_drive_enable |-> !tx_encoded_data && !tx_encoded_strobe)
    else $error("encoded outputs active while disabled");
  chk_ds_bit: assert property (tx_drive_enable && $changed(tx_encoded_data ^ tx_encoded_strobe)
    |=> $stable(tx_encoded_data ^ tx_encoded_strobe)[*3])
    else $error("encoded bit shorter than four clocks");
  chk_fifo_full: assert property ($fell(rx_ready) |-> $past(rx_valid))
    else $error("buffer refused without a push");
endmodule : phy_link_checker

bind backplane_phy_link_interface phy_link_checker chk_u (
  .clock(clock), .rst_n(rst_n), .link_clock_out(link_clock_out), .link_bus_out(link_bus_out),
  .link_bus_oe(link_bus_oe), .arb_drive_out(arb_drive_out), .tx_encoded_data(tx_encoded_data),
  .tx_encoded_strobe(tx_encoded_strobe), .tx_drive_enable(tx_drive_enable), .rx_valid(rx_valid),
  .rx_ready(rx_ready));

// ---- testbench/link_model.sv ----
`timescale 1ns/1ps
module link_model
  import bpl_pkg::*;
(
  input  wire logic      link_clock_out,
  input  wire link_bus_t link_bus_out,
  input  wire link_bus_t link_bus_oe,
  output link_bus_t      link_bus_in,
  output logic           link_request_line
);
  link_bus_t drive_val = 4'h4;

  // Only lines the device released carry the link's value; holds by default once granted
  assign link_bus_in = (link_bus_oe & link_bus_out) | (~link_bus_oe & drive_val);

  initial link_request_line = 1'b0;

  // Changes on the falling edge so the device samples a settled level
  task automatic send(input logic [16:0] bits, input int len);
    for (int i = 0; i < len; i++) begin
      @(negedge link_clock_out);
      link_request_line = bits[16-i];
    end
    @(negedge link_clock_out);
    link_request_line = 1'b0;
  endtask : send

  task automatic req_read(input logic [3:0] a);
    send({1'b1, 3'h4, a, 1'b0, 8'h00}, 9);
  endtask : req_read

  task automatic req_write(input logic [3:0] a, input logic [7:0] d);
    send({1'b1, 3'h5, a, d, 1'b0}, 17);
  endtask : req_write

  task automatic req_bus();
    send({1'b1, 3'h0, 6'h00, 1'b0, 6'h00}, 11);
  endtask : req_bus

  task automatic tx_byte(input logic [7:0] d);
    int k;
    k = 0;
    while (link_bus_oe !== 4'h0 && k < 40) begin
      @(negedge link_clock_out);
      k++;
    end
    for (int i = 3; i >= 0; i--) begin
      @(negedge link_clock_out);
      drive_val = {2'h2, d[2*i+:2]};
    end
    @(negedge link_clock_out);
    drive_val = 4'h0;
    k = 0;
    while (link_bus_oe !== 4'hf && k < 40) begin
      @(negedge link_clock_out);
      k++;
    end
    drive_val = 4'h4;
  endtask : tx_byte
endmodule : link_model

// ---- testbench/backplane_phy_link_interface_tb.sv ----
`timescale 1ns/1ps
module backplane_phy_link_interface_tb;
  import bpl_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n;
  logic        link_clock_out;
  link_bus_t   link_bus_in;
  link_bus_t   link_bus_out;
  link_bus_t   link_bus_oe;
  logic        link_request_line;
  logic        arb_drive_out;
  logic        rival_bit;
  logic        tx_encoded_data;
  logic        tx_encoded_strobe;
  logic        tx_drive_enable;
  rx_word_t    rx_word;
  logic        rx_valid;
  logic        rx_ready;
  logic        last_x = 1'b0;
  logic [1:0]  prev_ctl = 2'h0;
  logic [2:0]  scnt = 3'h0;
  logic [7:0]  sacc = 8'h00;
  logic [10:0] statq[$];
  logic [1:0]  rxq[$];
  logic        txq[$];
  int          miscompares = 0;
  int          compares = 0;

  always #50 clock = ~clock;
  wire backplane_readback = arb_drive_out | rival_bit;

  backplane_phy_link_interface dut_u (
    .clock(clock), .rst_n(rst_n), .link_clock_out(link_clock_out), .link_bus_in(link_bus_in),
    .link_bus_out(link_bus_out), .link_bus_oe(link_bus_oe), .link_request_line(link_request_line),
    .arb_drive_out(arb_drive_out), .backplane_readback(backplane_readback),
    .tx_encoded_data(tx_encoded_data), .tx_encoded_strobe(tx_encoded_strobe),
    .tx_drive_enable(tx_drive_enable), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
  link_model link_u (
    .link_clock_out(link_clock_out), .link_bus_out(link_bus_out), .link_bus_oe(link_bus_oe),
    .link_bus_in(link_bus_in), .link_request_line(link_request_line));

  task automatic expect_ok(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : expect_ok

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic wait_q();
    for (int k = 0; k < 4000 && statq.size() + rxq.size() + txq.size() != 0; k++) @(posedge clock);
    expect_ok(statq.size() + rxq.size() + txq.size() == 0, "result missing");
  endtask : wait_q

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    statq.push_back({3'h4, e});
    link_u.req_read(a);
    wait_q();
  endtask : rd

  // Status words and received pairs, read mid-period when settled
  always @(negedge link_clock_out) begin
    if (link_bus_oe === 4'hf && link_bus_out.ctl === 2'h1) begin
      scnt = scnt + 3'h1;
      sacc = {sacc[5:0], link_bus_out.data};
    end else if (scnt != 3'h0) begin
      expect_ok(statq.size() != 0 && statq[0] === {scnt, sacc}, "status word");
      if (statq.size() != 0) statq.delete(0);
      // Short status words must not inherit bits of the previous word
      scnt = 3'h0;
      sacc = 8'h00;
    end
    if (link_bus_oe === 4'hf && link_bus_out.ctl === 2'h2) begin
      if (prev_ctl !== 2'h2) expect_ok(link_bus_out.data === 2'h0, "receive lead");
      else if (rxq.size() != 0) expect_ok(link_bus_out.data === rxq.pop_front(), "receive pair");
    end
    prev_ctl = link_bus_out.ctl;
  end

  // Data-strobe: every bit flips data xor strobe
  always @(negedge clock) begin
    if (tx_drive_enable === 1'b1 && (tx_encoded_data ^ tx_encoded_strobe) !== last_x) begin
      expect_ok(txq.size() != 0 && txq[0] === tx_encoded_data, "encoded bit");
      if (txq.size() != 0) txq.delete(0);
    end
    last_x = tx_encoded_data ^ tx_encoded_strobe;
  end

  task automatic arb(input logic [9:0] own, input logic [9:0] rv, input logic inh, input logic [7:0] d);
    logic a_own, a_rv, b, g;
    int   k;
    a_own = 1'b1;
    a_rv = 1'b1;
    g = 1'b0;
    k = 0;
    link_u.req_write(4'h4, {4'h0, own[9:6]});
    link_u.req_write(4'h0, {2'h0, own[5:0]});
    link_u.req_write(4'h1, {7'h00, inh});
    link_u.req_bus();
    while (arb_drive_out !== 1'b1 && k < 400) begin
      @(posedge clock);
      #1;
      k++;
    end
    expect_ok(arb_drive_out === 1'b1, "arbitration start");
    for (int i = 9; i >= 0; i--) begin
      rival_bit = a_rv & rv[i];
      b = (a_own & own[i]) | rival_bit;
      @(negedge link_clock_out);
      expect_ok(arb_drive_out === (a_own & own[i]), "arbitration bit");
      a_own = a_own & (b == own[i]);
      a_rv = a_rv & (b == rv[i]);
      @(posedge link_clock_out);
      #1;
    end
    rival_bit = 1'b0;
    repeat (3) begin
      @(negedge link_clock_out);
      if (link_bus_oe === 4'hf && link_bus_out.ctl === 2'h3) g = 1'b1;
    end
    expect_ok(g === a_own, "grant");
    if (a_own) begin
      for (int i = 7; i >= 0; i--) if (!inh) txq.push_back(d[i]);
      link_u.tx_byte(d);
      wait_q();
      expect_ok(link_bus_oe === 4'hf, "lines not retaken");
    end
  endtask : arb

  initial begin
    logic [3:0] addrs[5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h2};
    logic [7:0] masks[5] = '{8'h3f, 8'h01, 8'h00, 8'h0f, 8'h00};
    logic [7:0] v;
    logic [9:0] own;
    rx_word_t   w;
    logic       full;
    rst_n = 1'b0;
    rival_bit = 1'b0;
    rx_valid = 1'b0;
    rx_word = '0;
    full = 1'b0;
    void'($urandom(73));
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    $display("test reset values finished");
    foreach (addrs[i]) begin
      v = 8'($urandom) & 8'hfd;
      link_u.req_write(addrs[i], v);
      rd(addrs[i], v & masks[i]);
    end
    $display("test register access finished");
    statq.push_back({3'h1, 8'h01});
    link_u.req_write(4'h1, 8'h02);
    wait_q();
    rd(4'h1, 8'h00);
    $display("test bus reset finished");
    own = {4'($urandom) | 4'h8, 6'($urandom)} & 10'h3fb;
    arb(own, own - 10'h1 - 10'($urandom % 4), 1'b0, 8'($urandom));
    $display("test arbitration won finished");
    arb(own, own + 10'h1 + 10'($urandom % 4), 1'b0, 8'h00);
    $display("test arbitration lost finished");
    arb(own, 10'h000, 1'b1, 8'($urandom));
    $display("test inhibited transmit finished");
    for (int i = 0; i < 12; i++) begin
      w = {i == 11, 2'($urandom)};
      rxq.push_back(w.data);
      rx_word = w;
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1) begin
        full = 1'b1;
        @(posedge clock);
        #1;
      end
      @(posedge clock);
      #1;
    end
    rx_valid = 1'b0;
    wait_q();
    expect_ok(full === 1'b1, "buffer never refused");
    $display("test receive finished");
    finish_test();
  end

  initial begin
    #4000000;
    miscompares++;
    finish_test();
  end
endmodule : backplane_phy_link_interface_tb
